//--- core/cpwu_channel.sv
// one compare channel: double buffer, match detect, output logic
// assumes a core that marks top, bottom, direction and tick
`default_nettype none
module cpwu_channel (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // core link
  cpwu_cmp_if.chan link,
  // control
  input wire logic [1:0] compare_output_mode,
  input wire logic allow_toggle,
  // results
  output logic waveform_out,
  output logic match_flag_set
);
  logic [15:0] act_reg;
  logic out_reg;
  logic out_next;
  wire buffered = link.is_fast | link.is_pc;
  wire do_load = ~buffered | link.load_top | link.load_bottom;
  wire hit = link.tick & (link.count == act_reg);
  wire pc_clear = (compare_output_mode == cpwu_pkg::COM_CLEAR)
    ^ link.dir_down;
  // ==========================================================
  // output next state
  always_comb
  begin
    out_next = out_reg;
    if (link.tick)
    begin
      if (compare_output_mode == cpwu_pkg::COM_TOGGLE)
      begin
        // in pwm modes toggle needs allow_toggle (modes 11 and 15 on a); ctc and normal always toggle
        if (hit & (allow_toggle | link.is_ctc | ~buffered))
          out_next = ~out_reg;
      end
      else if (compare_output_mode != cpwu_pkg::COM_OFF)
      begin
        if (link.is_pc)
        begin
          if (hit)
            out_next = ~pc_clear;
        end
        else if (link.is_fast)
        begin
          // match wins over top so compare equal to top holds level
          if (hit)
            out_next = (compare_output_mode == cpwu_pkg::COM_SET);
          else if (link.at_top)
            out_next = (compare_output_mode == cpwu_pkg::COM_CLEAR);
        end
        else if (hit)
          out_next = (compare_output_mode == cpwu_pkg::COM_SET);
      end
    end
  end
  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      act_reg <= cpwu_pkg::BOTTOM;
      out_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (do_load)
        act_reg <= link.buf_val;
      out_reg <= out_next;
    end
  end
  assign link.act_val = act_reg;
  assign link.match = hit;
  assign waveform_out = out_reg;
  assign match_flag_set = ce & hit;
endmodule
`default_nettype wire

//--- core/cpwu_cmp_if.sv
// interface joining the counter core to one compare channel
// assumes both ends sit on the same clock
`default_nettype none
interface cpwu_cmp_if;
  logic [15:0] count;
  logic tick;
  logic at_top;
  logic at_bottom;
  logic dir_down;
  logic is_fast;
  logic is_pc;
  logic is_ctc;
  logic load_top;
  logic load_bottom;
  logic [15:0] buf_val;
  logic [15:0] act_val;
  logic match;
  modport core (
    output count, tick, at_top, at_bottom, dir_down, is_fast, is_pc,
    output is_ctc, load_top, load_bottom,
    input act_val, match
  );
  modport chan (
    input count, tick, at_top, at_bottom, dir_down, is_fast, is_pc,
    input is_ctc, load_top, load_bottom,
    output act_val, match,
    input buf_val
  );
endinterface
`default_nettype wire

//--- core/cpwu_pkg.sv
// package of constants for the 16-bit counter waveform unit
// assumes a single clock domain and a timer tick supplied by a prescaler
`default_nettype none
package cpwu_pkg;
  // ==========================================================
  // widths and fixed values
  localparam int CNT_W = 16;
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] MAX_VAL = 16'hffff;
  localparam logic [15:0] TOP_8BIT = 16'h00ff;
  localparam logic [15:0] TOP_9BIT = 16'h01ff;
  localparam logic [15:0] TOP_10BIT = 16'h03ff;
  localparam logic [15:0] MIN_TOP = 16'h0003;
  // ==========================================================
  // waveform generation modes
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_PC8 = 4'h1;
  localparam logic [3:0] WGM_PC9 = 4'h2;
  localparam logic [3:0] WGM_PC10 = 4'h3;
  localparam logic [3:0] WGM_CTC_A = 4'h4;
  localparam logic [3:0] WGM_FAST8 = 4'h5;
  localparam logic [3:0] WGM_FAST9 = 4'h6;
  localparam logic [3:0] WGM_FAST10 = 4'h7;
  localparam logic [3:0] WGM_PC_CAP = 4'ha;
  localparam logic [3:0] WGM_PC_A = 4'hb;
  localparam logic [3:0] WGM_CTC_CAP = 4'hc;
  localparam logic [3:0] WGM_FAST_CAP = 4'he;
  localparam logic [3:0] WGM_FAST_A = 4'hf;
  // ==========================================================
  // compare output modes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  // ==========================================================
  // counter direction
  typedef enum logic [0:0] {
    CPWU_UP = 1'b0,
    CPWU_DOWN = 1'b1
  } cpwu_dir_e;
endpackage
`default_nettype wire

//--- core/cpwu_top.sv
// waveform unit of a 16-bit timer: fast pwm corners, phase correct pwm
// assumes timer_tick comes from a prescaler on clk, one cycle wide
// How it works
// - fast pwm with compare at bottom gives one narrow spike per period
// - fast pwm with compare at top holds output constant per polarity
// - fast pwm toggle mode toggles output a on match, mode 15 only
// - toggle with compare a zero gives half the io clock rate
// - fast pwm keeps compare double buffering, also while toggling
// - phase correct pwm for modes 1, 2, 3, 10 and 11
// - phase correct counts up bottom to top then down to bottom
// - non-inverting: clear on up-count match, set on down-count match
// - inverting: set on up-count match, clear on down-count match
// - top fixed 0xff, 0x1ff, 0x3ff, or capture value, or compare a
// - counter reverses at top and holds top for one tick
// - compare match sets the channel match flag
`default_nettype none
module cpwu_top #(
  parameter int CNT_W = cpwu_pkg::CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // timer clock from prescaler
  input wire logic timer_tick,
  // configuration
  input wire logic [3:0] waveform_gen_mode,
  input wire logic [1:0] compare_output_mode_a,
  input wire logic [1:0] compare_output_mode_b,
  input wire logic [15:0] compare_value_a,
  input wire logic [15:0] compare_value_b,
  input wire logic [15:0] capture_value_reg,
  // flag clears from software
  input wire logic flag_a_clear,
  input wire logic flag_b_clear,
  input wire logic flag_top_clear,
  // outputs
  output logic waveform_out_a,
  output logic waveform_out_b,
  output logic [15:0] counter_value,
  output logic count_down,
  output logic match_flag_a,
  output logic match_flag_b,
  output logic top_flag
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  cpwu_pkg::cpwu_dir_e dir_reg;
  cpwu_pkg::cpwu_dir_e dir_next;
  logic flag_a_reg;
  logic flag_b_reg;
  logic top_flag_reg;
  logic [15:0] top_val;
  logic [15:0] act_a;
  logic is_pc;
  logic is_fast;
  logic is_ctc;
  logic uses_a_top;
  logic at_top;
  logic at_bottom;
  logic set_a;
  logic set_b;
  cpwu_cmp_if if_a ();
  cpwu_cmp_if if_b ();

  // ==========================================================
  // mode decoding
  function automatic logic mode_pc(input logic [3:0] m);
    mode_pc = (m == cpwu_pkg::WGM_PC8) | (m == cpwu_pkg::WGM_PC9) |
      (m == cpwu_pkg::WGM_PC10) | (m == cpwu_pkg::WGM_PC_CAP) |
      (m == cpwu_pkg::WGM_PC_A);
  endfunction

  function automatic logic mode_fast(input logic [3:0] m);
    mode_fast = (m == cpwu_pkg::WGM_FAST8) | (m == cpwu_pkg::WGM_FAST9) |
      (m == cpwu_pkg::WGM_FAST10) | (m == cpwu_pkg::WGM_FAST_CAP) |
      (m == cpwu_pkg::WGM_FAST_A);
  endfunction

  assign is_pc = mode_pc(waveform_gen_mode);
  assign is_fast = mode_fast(waveform_gen_mode);
  assign is_ctc = (waveform_gen_mode == cpwu_pkg::WGM_CTC_A) |
    (waveform_gen_mode == cpwu_pkg::WGM_CTC_CAP);
  assign uses_a_top = (waveform_gen_mode == cpwu_pkg::WGM_PC_A) |
    (waveform_gen_mode == cpwu_pkg::WGM_FAST_A) |
    (waveform_gen_mode == cpwu_pkg::WGM_CTC_A);

  // ==========================================================
  // top selection
  // variable top below 0x0003 is not guarded; software keeps it legal
  always_comb
  begin
    case (waveform_gen_mode)
      cpwu_pkg::WGM_PC8, cpwu_pkg::WGM_FAST8:
        top_val = cpwu_pkg::TOP_8BIT;
      cpwu_pkg::WGM_PC9, cpwu_pkg::WGM_FAST9:
        top_val = cpwu_pkg::TOP_9BIT;
      cpwu_pkg::WGM_PC10, cpwu_pkg::WGM_FAST10:
        top_val = cpwu_pkg::TOP_10BIT;
      cpwu_pkg::WGM_PC_CAP, cpwu_pkg::WGM_CTC_CAP, cpwu_pkg::WGM_FAST_CAP:
        top_val = capture_value_reg;
      cpwu_pkg::WGM_PC_A, cpwu_pkg::WGM_CTC_A, cpwu_pkg::WGM_FAST_A:
        top_val = act_a;
      default:
        top_val = cpwu_pkg::MAX_VAL;
    endcase
  end

  assign at_top = (cnt_reg == top_val);
  assign at_bottom = (cnt_reg == cpwu_pkg::BOTTOM);

  // ==========================================================
  // counter next state
  always_comb
  begin
    cnt_next = cnt_reg;
    dir_next = dir_reg;
    if (timer_tick)
    begin
      if (is_pc)
      begin
        // top is held for exactly one tick, then the count turns
        if (at_top)
        begin
          dir_next = cpwu_pkg::CPWU_DOWN;
          // a variable top still at zero before its first load must not
          // wrap the count below bottom
          if (~at_bottom)
            cnt_next = cnt_reg - 16'h0001;
        end
        else if (dir_reg == cpwu_pkg::CPWU_DOWN & ~at_bottom)
          cnt_next = cnt_reg - 16'h0001;
        else
        begin
          dir_next = cpwu_pkg::CPWU_UP;
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      else
      begin
        dir_next = cpwu_pkg::CPWU_UP;
        if (at_top)
          cnt_next = cpwu_pkg::BOTTOM;
        else
          cnt_next = cnt_reg + 16'h0001;
      end
    end
  end

  // ==========================================================
  // counter and flag registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg <= cpwu_pkg::BOTTOM;
      dir_reg <= cpwu_pkg::CPWU_UP;
    end
    else if (ce)
    begin
      cnt_reg <= cnt_next;
      dir_reg <= dir_next;
    end
  end

  // set wins over clear so a match in the clearing cycle is kept
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
      top_flag_reg <= 1'b0;
    end
    else if (ce)
    begin
      flag_a_reg <= set_a | (flag_a_reg & ~flag_a_clear);
      flag_b_reg <= set_b | (flag_b_reg & ~flag_b_clear);
      top_flag_reg <= (timer_tick & at_top) |
        (top_flag_reg & ~flag_top_clear);
    end
  end

  // ==========================================================
  // channel links
  // phase correct loads at top, fast pwm at the wrap to bottom
  assign if_a.count = cnt_reg;
  assign if_a.tick = timer_tick;
  assign if_a.at_top = at_top;
  assign if_a.at_bottom = at_bottom;
  assign if_a.dir_down = (dir_reg == cpwu_pkg::CPWU_DOWN) & ~at_top;
  assign if_a.is_fast = is_fast;
  assign if_a.is_pc = is_pc;
  assign if_a.is_ctc = is_ctc;
  assign if_a.load_top = timer_tick & at_top & is_pc;
  assign if_a.load_bottom = timer_tick & at_top & is_fast;
  assign if_a.buf_val = compare_value_a;
  assign if_b.count = cnt_reg;
  assign if_b.tick = timer_tick;
  assign if_b.at_top = at_top;
  assign if_b.at_bottom = at_bottom;
  assign if_b.dir_down = (dir_reg == cpwu_pkg::CPWU_DOWN) & ~at_top;
  assign if_b.is_fast = is_fast;
  assign if_b.is_pc = is_pc;
  assign if_b.is_ctc = is_ctc;
  assign if_b.load_top = timer_tick & at_top & is_pc;
  assign if_b.load_bottom = timer_tick & at_top & is_fast;
  assign if_b.buf_val = compare_value_b;
  assign act_a = if_a.act_val;

  cpwu_channel u_chan_a (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .link(if_a),
    .compare_output_mode(compare_output_mode_a),
    .allow_toggle(uses_a_top),
    .waveform_out(waveform_out_a),
    .match_flag_set(set_a)
  );

  cpwu_channel u_chan_b (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .link(if_b),
    .compare_output_mode(compare_output_mode_b),
    .allow_toggle(1'b0),
    .waveform_out(waveform_out_b),
    .match_flag_set(set_b)
  );

  assign counter_value = cnt_reg;
  assign count_down = (dir_reg == cpwu_pkg::CPWU_DOWN);
  assign match_flag_a = flag_a_reg;
  assign match_flag_b = flag_b_reg;
  assign top_flag = top_flag_reg;
endmodule
`default_nettype wire

//--- verification/cpwu_assertions.sv
// assertions on the ports of the waveform unit top
// assumes bound to cpwu_top, and a reset before every change of mode
`default_nettype none
module cpwu_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic timer_tick,
  // configuration
  input wire logic [3:0] waveform_gen_mode,
  input wire logic [1:0] compare_output_mode_a,
  input wire logic [15:0] compare_value_a,
  input wire logic [15:0] capture_value_reg,
  // outputs
  input wire logic waveform_out_a,
  input wire logic [15:0] counter_value,
  input wire logic count_down,
  input wire logic match_flag_a
);
  // ========
  // helper copy of active compare a
  logic tk, pc, fst, hit, at_top;
  logic [15:0] top_w;
  logic [15:0] act_reg;
  assign tk = ce & timer_tick;
  assign pc = waveform_gen_mode inside {4'h1, 4'h2, 4'h3, 4'ha};
  assign fst = waveform_gen_mode inside {4'h5, 4'h6, 4'h7};
  // fixed tops are 0x100, 0x200, 0x400 less one
  assign top_w = waveform_gen_mode == 4'ha ? capture_value_reg
    : (16'h0080 << waveform_gen_mode[1:0]) - 16'h0001;
  assign at_top = counter_value == top_w;
  assign hit = tk & (counter_value == act_reg);
  // only trusted in checked modes: mode 11 and 15 tops are not modelled
  always_ff @(posedge clk)
  begin
    if (rst)
      act_reg <= 16'h0000;
    else if (tk & at_top)
      act_reg <= compare_value_a;
  end
  // ========
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_top;
    tk && pc && at_top;
  endsequence
  sequence s_turned;
    count_down && counter_value == top_w - 16'h0001;
  endsequence
  a_up_step: assert property (
    tk && pc && !count_down && counter_value < top_w
    |=> counter_value == $past(counter_value) + 16'h0001)
    else $error("up count step wrong");
  a_down_step: assert property (
    tk && pc && count_down && counter_value != 16'h0 && !at_top
    |=> counter_value == $past(counter_value) - 16'h0001)
    else $error("down count step wrong");
  a_top_turn: assert property (s_top |=> s_turned)
    else $error("no turn after one top tick");
  a_bottom_turn: assert property (
    tk && pc && count_down && counter_value == 16'h0
    |=> !count_down && counter_value == 16'h0001)
    else $error("no turn at bottom");
  a_pc_noninv: assert property (
    hit && pc && compare_output_mode_a == 2'h2 && !at_top
    |=> waveform_out_a == $past(count_down))
    else $error("non-inverting output wrong");
  a_pc_inv: assert property (
    hit && pc && compare_output_mode_a == 2'h3 && !at_top
    |=> waveform_out_a == !$past(count_down))
    else $error("inverting output wrong");
  a_flag_set: assert property (hit && (pc || fst) |=> match_flag_a)
    else $error("match flag not set");
  a_fast_hit: assert property (
    hit && fst && compare_output_mode_a[1]
    |=> waveform_out_a == $past(compare_output_mode_a[0]))
    else $error("fast match level wrong");
  a_fast_wrap: assert property (
    tk && fst && compare_output_mode_a[1] && at_top && act_reg != top_w
    |=> waveform_out_a == !$past(compare_output_mode_a[0]))
    else $error("fast wrap level wrong");
  a_no_toggle: assert property (
    tk && fst && compare_output_mode_a == 2'h1 |=> $stable(waveform_out_a))
    else $error("toggle outside mode 15");
  a_freeze: assert property (
    !tk |=> $stable(counter_value) && $stable(waveform_out_a))
    else $error("state moved without tick");
endmodule
bind cpwu_top cpwu_assertions cpwu_assertions_inst (.*);
`default_nettype wire

//--- verification/cpwu_top_tb.sv
// self-checking bench for the waveform unit top
// assumes a tick every clock unless a test stops it
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module cpwu_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic timer_tick = 1'b1;
  logic [3:0] waveform_gen_mode = 4'h1;
  logic [1:0] compare_output_mode_a = 2'h2;
  logic [1:0] compare_output_mode_b = 2'h2;
  logic [15:0] compare_value_a = 16'h0000;
  logic [15:0] compare_value_b = 16'h0020;
  logic [15:0] capture_value_reg = 16'h0003;
  logic flag_a_clear = 1'b0;
  logic flag_b_clear = 1'b0;
  logic flag_top_clear = 1'b0;
  logic waveform_out_a, waveform_out_b, count_down;
  logic match_flag_a, match_flag_b, top_flag;
  logic [15:0] counter_value, prev;
  int errors = 0;
  int n_tests = 0;
  cpwu_top cpwu_top_inst (.*);
  always #5 clk = ~clk;
  // ========
  // helpers, all entered and left at a falling edge
  task automatic rs(input logic [3:0] m, input logic [1:0] c);
    rst = 1'b1;
    waveform_gen_mode = m;
    compare_output_mode_a = c;
    repeat (2) @(negedge clk);
    rst = 1'b0;
  endtask
  task automatic wd(input logic v);
    for (int k = 0; k < 5000 && count_down !== v; k++)
    begin
      prev = counter_value;
      @(negedge clk);
    end
    `CHK("direction wait", v, count_down)
  endtask
  task automatic wc(input logic [15:0] v);
    for (int k = 0; k < 5000 && counter_value !== v; k++)
      @(negedge clk);
    `CHK("count wait", v, counter_value)
  endtask
  task automatic highs(input int n, output int h);
    h = 0;
    repeat (n)
    begin
      @(negedge clk);
      h += waveform_out_a;
    end
  endtask
  // ========
  // tests
  task automatic t_hold;
    rs(4'h1, 2'h2);
    repeat (9) @(negedge clk);
    timer_tick = 1'b0;
    prev = counter_value;
    repeat (3) @(negedge clk);
    ce = 1'b0;
    timer_tick = 1'b1;
    repeat (3) @(negedge clk);
    `CHK("frozen", prev, counter_value)
    ce = 1'b1;
    @(negedge clk);
    `CHK("step", prev + 16'h0001, counter_value)
    $display("t_hold done");
  endtask
  task automatic t_modes;
    logic [3:0] md [5] = '{4'h1, 4'h2, 4'h3, 4'ha, 4'hb};
    logic [15:0] tp [5] = '{16'h00ff, 16'h01ff, 16'h03ff, 16'h3, 16'h5};
    compare_value_a = 16'h0005;
    foreach (md[i])
    begin
      rs(md[i], 2'h2);
      wd(1'b1);
      wd(1'b0);
      wd(1'b1);
      `CHK("top", tp[i], prev)
      `CHK("turn", tp[i] - 16'h0001, counter_value)
    end
    $display("t_modes done");
  endtask
  task automatic t_pc;
    for (int c = 2; c < 4; c++)
    begin
      rs(4'h1, c[1:0]);
      compare_value_a = 16'h0010;
      wd(1'b1);
      wd(1'b0);
      wc(16'h0011);
      `CHK("up out", c[0], waveform_out_a)
      `CHK("flag", 1'b1, match_flag_a)
      flag_a_clear = 1'b1;
      @(negedge clk);
      flag_a_clear = 1'b0;
      `CHK("cleared", 1'b0, match_flag_a)
      wd(1'b1);
      wc(16'h000f);
      `CHK("down out", !c[0], waveform_out_a)
    end
    $display("t_pc done");
  endtask
  task automatic t_fast;
    int h;
    // the spike needs compare a at bottom from the first top onwards
    compare_value_a = 16'h0000;
    rs(4'h5, 2'h2);
    highs(512, h);
    `CHK("spike", 2, h)
    wc(16'h0010);
    compare_value_a = 16'h0080;
    wc(16'h0040);
    `CHK("buffered", 1'b0, waveform_out_a)
    wc(16'h0000);
    wc(16'h0040);
    `CHK("loaded", 1'b1, waveform_out_a)
    compare_value_a = 16'h00ff;
    for (int c = 2; c < 4; c++)
    begin
      compare_output_mode_a = c[1:0];
      wc(16'h0000);
      highs(256, h);
      highs(256, h);
      `CHK("top level", c == 3 ? 256 : 0, h)
    end
    $display("t_fast done");
  endtask
  task automatic t_toggle;
    int h;
    logic v;
    compare_value_a = 16'h0000;
    rs(4'hf, 2'h1);
    repeat (4) @(negedge clk);
    repeat (6)
    begin
      v = waveform_out_a;
      @(negedge clk);
      `CHK("toggle", !v, waveform_out_a)
    end
    rs(4'h5, 2'h1);
    highs(300, h);
    `CHK("no toggle", 0, h)
    // fast pwm with top from the capture value wraps to bottom
    rs(4'he, 2'h2);
    wc(16'h0003);
    @(negedge clk);
    `CHK("fast cap wrap", 16'h0000, counter_value)
    $display("t_toggle done");
  endtask
  task automatic t_flags;
    rs(4'h1, 2'h2);
    wd(1'b1);
    `CHK("top flag", 1'b1, top_flag)
    flag_top_clear = 1'b1;
    @(negedge clk);
    flag_top_clear = 1'b0;
    `CHK("top cleared", 1'b0, top_flag)
    wc(16'h001f);
    `CHK("b down out", 1'b1, waveform_out_b)
    `CHK("b flag", 1'b1, match_flag_b)
    wd(1'b0);
    wc(16'h001f);
    // clear held over the match cycle: the set must win there
    flag_b_clear = 1'b1;
    @(negedge clk);
    `CHK("b cleared", 1'b0, match_flag_b)
    @(negedge clk);
    flag_b_clear = 1'b0;
    `CHK("b set wins", 1'b1, match_flag_b)
    `CHK("b up out", 1'b0, waveform_out_b)
    $display("t_flags done");
  endtask
  task automatic print_verdict;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_hold;
    t_modes;
    t_pc;
    t_flags;
    t_fast;
    t_toggle;
    print_verdict;
  end
  // about 10400 cycles expected, so 30000 means a hang
  initial
  begin
    #300000;
    errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
